//--- rtl/pds_divider.sv
`timescale 1ns/1ps
module pds_divider (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rstSync_b,
  // Local oscillator edges
  input  wire logic            hbEdge,
  input  wire logic            lbEdge,
  // Configuration
  input  wire pds_pkg::pds_cfg_t cfg,
  // Divided output
  output logic                 divPulse_ff,
  output logic                 badDiv_ff
);

  logic        prescale_ff;
  logic [15:0] cnt_ff;
  logic        legal;
  logic        inEdge;
  logic        countEdge;
  logic [15:0] loadVal;

  assign legal   = pds_pkg::divisor_legal(cfg);
  assign inEdge  = cfg.bandSelectBit ? hbEdge : lbEdge;
  // High band counts every second edge
  assign countEdge = inEdge && (!cfg.bandSelectBit || prescale_ff);
  // Direct path only honours twelve bits
  assign loadVal = (cfg.bandSelectBit || cfg.lowBandPathBit) ? cfg.divisor
                                                             : {4'h0, cfg.divisor[11:0]};

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      prescale_ff <= 1'b0;
    end else if (!cfg.bandSelectBit) begin
      prescale_ff <= 1'b0;
    end else if (hbEdge) begin
      prescale_ff <= !prescale_ff;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      cnt_ff      <= pds_pkg::CFG_RST.divisor;
      divPulse_ff <= 1'b0;
    end else if (!legal) begin
      // Held at this divisor's reload value; a later legal divisor's first period counts down from it
      cnt_ff      <= loadVal;
      divPulse_ff <= 1'b0;
    end else if (countEdge) begin
      if (cnt_ff <= 16'h0001) begin
        cnt_ff      <= loadVal;
        divPulse_ff <= 1'b1;
      end else begin
        cnt_ff      <= cnt_ff - 16'h0001;
        divPulse_ff <= 1'b0;
      end
    end else begin
      divPulse_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      badDiv_ff <= 1'b0;
    end else begin
      badDiv_ff <= !legal;
    end
  end

endmodule : pds_divider

//--- rtl/pds_input_select.sv
`timescale 1ns/1ps
module pds_input_select (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Serial link pins
  input  wire logic        serialEnable,
  input  wire logic        serial_clock_line,
  input  wire logic        serial_in_line,
  output logic             serialOutData,
  output logic             serialOutOe,
  // Local oscillator inputs
  input  wire logic        high_band_lo_input,
  input  wire logic        low_band_lo_input,
  // Divided signal toward the phase comparator
  output logic             divOut,
  // Dedicated open-drain outputs, enable high pulls low
  output logic [4:0]       portOut,
  output logic [4:0]       portOe,
  output logic             bandPortOut,
  output logic             bandPortOe,
  // Dual-use pins
  input  wire logic [1:0]  ioIn,
  output logic [1:0]       ioOut,
  output logic [1:0]       ioOe,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int NPIN = 7;

  logic [1:0]            rstPipe_ff;
  logic                  rstSync_b;
  logic [NPIN-1:0]       pinS1_ff;
  logic [NPIN-1:0]       pinS2_ff;
  logic [NPIN-1:0]       pinS3_ff;
  logic [NPIN-1:0]       pinF_ff;
  logic [NPIN-1:0]       pinPrev_ff;
  logic [NPIN-1:0]       rawPins;
  pds_pkg::pds_serial_t  ser;
  logic                  clRise;
  logic                  clFall;
  logic                  ceFall;
  logic                  hbEdge;
  logic                  lbEdge;
  logic [pds_pkg::FRAME_BITS-1:0] shift_ff;
  logic [4:0]            bitCnt_ff;
  pds_pkg::pds_cfg_t     cfg_ff;
  logic [8:0]            ports_ff;
  logic                  divPulse;
  logic                  badDiv;
  logic                  divLevel_ff;
  logic                  nxt_doBit;
  logic                  awTaken_ff;
  logic                  wTaken_ff;
  logic [3:0]            awAddr_ff;
  logic [31:0]           wData_ff;
  logic [3:0]            wStrb_ff;
  logic [31:0]           statusWord;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstPipe_ff <= 2'h0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstSync_b = rstPipe_ff[1];

  // Three-flop pin sampling; a change counts once stages two and three agree
  assign rawPins = {ioIn, low_band_lo_input, high_band_lo_input,
                    serial_in_line, serial_clock_line, serialEnable};

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      pinS1_ff   <= '0;
      pinS2_ff   <= '0;
      pinS3_ff   <= '0;
      pinF_ff    <= '0;
      pinPrev_ff <= '0;
    end else begin
      pinS1_ff   <= rawPins;
      pinS2_ff   <= pinS1_ff;
      pinS3_ff   <= pinS2_ff;
      pinF_ff    <= (pinS2_ff & pinS3_ff) | (pinF_ff & ~(pinS2_ff ^ pinS3_ff) & pinS3_ff)
                    | (pinF_ff & (pinS2_ff ^ pinS3_ff));
      pinPrev_ff <= pinF_ff;
    end
  end

  assign ser    = '{ce: pinF_ff[0], cl: pinF_ff[1], di: pinF_ff[2]};
  assign clRise = ser.cl && !pinPrev_ff[1] && ser.ce;
  assign clFall = !ser.cl && pinPrev_ff[1] && ser.ce;
  assign ceFall = !ser.ce && pinPrev_ff[0];
  // LO inputs above a few MHz alias at this sampling rate
  assign hbEdge = pinF_ff[3] && !pinPrev_ff[3];
  assign lbEdge = pinF_ff[4] && !pinPrev_ff[4];

  // Serial receive: data input is only ever shifted in
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      shift_ff  <= '0;
      bitCnt_ff <= 5'h00;
    end else if (!ser.ce) begin
      bitCnt_ff <= 5'h00;
    end else if (clRise) begin
      shift_ff  <= {shift_ff[pds_pkg::FRAME_BITS-2:0], ser.di};
      if (bitCnt_ff != 5'h1F) begin
        bitCnt_ff <= bitCnt_ff + 5'h01;
      end
    end
  end

  // Configuration lands only on a complete frame, so a short burst is ignored
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      cfg_ff <= pds_pkg::CFG_RST;
    end else if (ceFall && bitCnt_ff == 5'(pds_pkg::FRAME_BITS)) begin
      cfg_ff.divisor        <= shift_ff[pds_pkg::DIV_LSB +: 16];
      cfg_ff.bandSelectBit  <= shift_ff[pds_pkg::BAND_BIT];
      cfg_ff.lowBandPathBit <= shift_ff[pds_pkg::PATH_BIT];
      cfg_ff.docSel         <= shift_ff[pds_pkg::DOC_LSB +: 3];
    end
  end

  pds_divider u_divider (
    .clk         (clk),
    .rstSync_b   (rstSync_b),
    .hbEdge      (hbEdge),
    .lbEdge      (lbEdge),
    .cfg         (cfg_ff),
    .divPulse_ff (divPulse),
    .badDiv_ff   (badDiv)
  );

  assign divOut = divPulse;

  // Divided signal as a level that toggles per period, readable on the data output
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      divLevel_ff <= 1'b0;
    end else if (divPulse) begin
      divLevel_ff <= !divLevel_ff;
    end
  end

  always_comb begin
    unique case (cfg_ff.docSel)
      pds_pkg::DOC_DIVOUT: nxt_doBit = divLevel_ff;
      pds_pkg::DOC_IO1:    nxt_doBit = pinF_ff[5];
      pds_pkg::DOC_IO2:    nxt_doBit = pinF_ff[6];
      pds_pkg::DOC_BADDIV: nxt_doBit = badDiv;
      pds_pkg::DOC_BAND:   nxt_doBit = cfg_ff.bandSelectBit;
      default:             nxt_doBit = 1'b1;
    endcase
  end

  // Output loads as enable rises and changes on serial clock falling edge so the controller samples on rising
  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      serialOutData <= 1'b0;
      serialOutOe   <= 1'b0;
    end else if (!ser.ce) begin
      serialOutOe   <= 1'b0;
    end else if (clFall || !pinPrev_ff[0]) begin
      serialOutOe   <= !nxt_doBit;
    end
  end

  // Port pins: open-drain, enable pulls low
  assign portOut     = 5'h00;
  assign portOe      = ports_ff[pds_pkg::PORT_OUT_LSB +: 5];
  assign bandPortOut = 1'b0;
  assign bandPortOe  = cfg_ff.bandSelectBit;
  assign ioOut       = 2'h0;
  assign ioOe        = ports_ff[pds_pkg::IO_DIR_LSB +: 2]
                       & ports_ff[pds_pkg::IO_OUT_LSB +: 2];

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !awTaken_ff && !s_axi_bvalid;
  assign s_axi_wready  = !wTaken_ff && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      awTaken_ff   <= 1'b0;
      wTaken_ff    <= 1'b0;
      awAddr_ff    <= 4'h0;
      wData_ff     <= 32'h0000_0000;
      wStrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pds_pkg::RESP_OKAY;
      ports_ff     <= pds_pkg::PORTS_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awTaken_ff <= 1'b1;
        awAddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wTaken_ff <= 1'b1;
        wData_ff  <= s_axi_wdata;
        wStrb_ff  <= s_axi_wstrb;
      end
      if (awTaken_ff && wTaken_ff) begin
        awTaken_ff   <= 1'b0;
        wTaken_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr_ff[3:2] == pds_pkg::ADDR_PORTS[3:2]) begin
          s_axi_bresp <= pds_pkg::RESP_OKAY;
          if (wStrb_ff[0]) begin
            ports_ff[7:0] <= wData_ff[7:0];
          end
          if (wStrb_ff[1]) begin
            ports_ff[8] <= wData_ff[8];
          end
        end else begin
          s_axi_bresp <= pds_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign statusWord = {25'h0, pinF_ff[6:5], badDiv, divLevel_ff, cfg_ff.docSel == 3'h0,
                       cfg_ff.lowBandPathBit, cfg_ff.bandSelectBit};

  // AXI4-Lite read: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge rstSync_b) begin
    if (!rstSync_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= pds_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= pds_pkg::RESP_OKAY;
      unique case (s_axi_araddr[3:2])
        pds_pkg::ADDR_PORTS[3:2]:  s_axi_rdata <= {23'h0, ports_ff};
        pds_pkg::ADDR_STATUS[3:2]: s_axi_rdata <= statusWord;
        pds_pkg::ADDR_CONFIG[3:2]: s_axi_rdata <= {11'h0, cfg_ff.docSel,
                                                   cfg_ff.lowBandPathBit,
                                                   cfg_ff.bandSelectBit, cfg_ff.divisor};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= pds_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : pds_input_select

//--- rtl/pds_pkg.sv
package pds_pkg;

  // Serial frame: divisor in low bits, then band, path, content select
  localparam int FRAME_BITS      = 24;
  localparam int DIV_LSB         = 0;
  localparam int BAND_BIT        = 16;
  localparam int PATH_BIT        = 17;
  localparam int DOC_LSB         = 18;

  localparam logic [15:0] SWALLOW_MIN = 16'h0110;
  localparam logic [15:0] SWALLOW_MAX = 16'hFFFF;
  localparam logic [15:0] DIRECT_MIN  = 16'h0004;
  localparam logic [15:0] DIRECT_MAX  = 16'h0FFF;

  // AXI4-Lite register map (byte addresses)
  localparam logic [3:0] ADDR_PORTS  = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_CONFIG = 4'h8;

  // Port control register fields
  localparam int PORT_OUT_LSB = 0;
  localparam int IO_DIR_LSB   = 5;
  localparam int IO_OUT_LSB   = 7;
  localparam logic [8:0] PORTS_RST = 9'h000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Data output content select codes
  localparam logic [2:0] DOC_OPEN    = 3'h0;
  localparam logic [2:0] DOC_DIVOUT  = 3'h1;
  localparam logic [2:0] DOC_IO1     = 3'h2;
  localparam logic [2:0] DOC_IO2     = 3'h3;
  localparam logic [2:0] DOC_BADDIV  = 3'h4;
  localparam logic [2:0] DOC_BAND    = 3'h5;

  typedef struct packed {
    logic [2:0]  docSel;
    logic        lowBandPathBit;
    logic        bandSelectBit;
    logic [15:0] divisor;
  } pds_cfg_t;

  localparam pds_cfg_t CFG_RST = '{docSel: 3'h0, lowBandPathBit: 1'b0,
                                   bandSelectBit: 1'b0, divisor: 16'h0004};

  typedef struct packed {
    logic ce;
    logic cl;
    logic di;
  } pds_serial_t;

  function automatic logic divisor_legal(input pds_cfg_t c);
    if (c.bandSelectBit || c.lowBandPathBit) begin
      divisor_legal = (c.divisor >= SWALLOW_MIN) && (c.divisor <= SWALLOW_MAX);
    end else begin
      divisor_legal = (c.divisor >= DIRECT_MIN) && (c.divisor <= DIRECT_MAX);
    end
  endfunction : divisor_legal

endpackage : pds_pkg

//--- tb/pds_ctrl_model.sv
`timescale 1ns/1ps
module pds_ctrl_model (
  // Clock
  input wire logic clk,
  // Serial bus toward the device
  output logic     serialEnable,
  output logic     serial_clock_line,
  output logic     serial_in_line,
  input wire logic doLine
);
  initial begin
    serialEnable = 1'b0;
    serial_clock_line = 1'b0;
    serial_in_line = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // Four cycles a half period gives the 80 ns link clock; it rests low between frames
  task automatic send(input logic [23:0] f, input int nb);
    int i;
    serialEnable <= 1'b1;
    for (i = 0; i < nb; i++) begin
      serial_in_line <= f[23 - i];
      hold(4);
      serial_clock_line <= 1'b1;
      hold(4);
      serial_clock_line <= 1'b0;
    end
    hold(4);
    serialEnable <= 1'b0;
    // No pull on the data line, so show the inverse once released
    serial_in_line <= ~serial_in_line;
    hold(20);
  endtask : send

  task automatic fetch(output logic b);
    serialEnable <= 1'b1;
    hold(12);
    b = doLine;
    serialEnable <= 1'b0;
    hold(12);
  endtask : fetch
endmodule : pds_ctrl_model

//--- tb/pds_monitor.sv
`timescale 1ns/1ps
module pds_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Pins
  input wire logic        serialEnable,
  input wire logic        serialOutData,
  input wire logic        serialOutOe,
  input wire logic        divOut,
  input wire logic [4:0]  portOut,
  input wire logic [4:0]  portOe,
  input wire logic        bandPortOut,
  input wire logic        bandPortOe,
  input wire logic [1:0]  ioOut,
  input wire logic [1:0]  ioOe,
  // AXI4-Lite
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  AST_OPEN_AFTER_RESET: assert property ($rose(rst_b) |->
    portOe == 5'h00 && ioOe == 2'h0 && !bandPortOe && !serialOutOe) else $error("pins driven");
  AST_PORT_DATA_LOW: assert property (portOut == 5'h00 && !bandPortOut &&
    ioOut == 2'h0 && !serialOutData) else $error("port data high");
  // Port enables may only move on the edge that raises the write response
  AST_PORT_ON_WRITE: assert property ($changed({portOe, ioOe}) |->
    $rose(s_axi_bvalid)) else $error("port moved without write");
  AST_DO_RELEASED: assert property (!serialEnable [*8] |-> !serialOutOe)
    else $error("data out held");
  AST_DIV_ONE_PULSE: assert property (divOut |=> !divOut [*8])
    else $error("divider pulse too long");
  // Config only moves after a frame ends, so a long enable keeps the band pin
  AST_BAND_STEADY: assert property (serialEnable [*8] |-> $stable(bandPortOe))
    else $error("band moved mid frame");
  AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid && s_axi_bresp == ($past(s_axi_awaddr[3:2], 2) == 2'h0 ? 2'h0 : 2'h2))
    else $error("bad bresp");
  AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid &&
    s_axi_rresp == ($past(s_axi_araddr[3:2]) == 2'h3 ? 2'h2 : 2'h0)) else $error("bad rresp");
  AST_B_HOLD: assert property (s_axi_bvalid |=> s_axi_bvalid != $past(s_axi_bready) &&
    ($past(s_axi_bready) || $stable(s_axi_bresp))) else $error("bvalid dropped");

  cover property (divOut);
  cover property (serialOutOe);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : pds_monitor

bind pds_input_select pds_monitor u_mon (.*);

//--- tb/pll_divider_input_select_bench.sv
`timescale 1ns/1ps
module pll_divider_input_select_bench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        high_band_lo_input = 1'b0;
  logic        low_band_lo_input = 1'b0;
  logic [1:0]  ioIn = 2'h0;
  logic [3:0]  s_axi_awaddr = 4'h0;
  logic [3:0]  s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, ioOut, ioOe;
  logic [31:0] s_axi_rdata;
  logic [4:0]  portOut, portOe;
  logic        serialEnable, serial_clock_line, serial_in_line, serialOutData, serialOutOe;
  logic        divOut, bandPortOut, bandPortOe;
  logic        curBand = 1'b0;
  wire         doLine = !serialOutOe;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          hbCnt = 0;
  int          lbCnt = 0;
  int          pulseCnt = 0;
  int          marks[$];

  pds_input_select DUT (.*);
  pds_ctrl_model CTRL (.*);

  always #5 clk = ~clk;

  // Two unrelated LO rates: only the selected one may set the pulse spacing
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles % 5 == 0) high_band_lo_input <= ~high_band_lo_input;
    if (cycles % 5 == 0 && !high_band_lo_input) hbCnt <= hbCnt + 1;
    if (cycles % 7 == 0) low_band_lo_input <= ~low_band_lo_input;
    if (cycles % 7 == 0 && !low_band_lo_input) lbCnt <= lbCnt + 1;
    if (divOut === 1'b1) marks.push_back(curBand ? hbCnt : lbCnt);
    if (divOut === 1'b1) pulseCnt <= pulseCnt + 1;
    // The whole run needs about 40k cycles; the high-band divide is the slowest part
    if (cycles == 60000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check32

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) miscompares++;
    // One idle edge so a following call never rewrites a ready in the same step
    @(posedge clk);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) miscompares++;
    @(posedge clk);
  endtask : axi_rd

  // Input edges per output pulse, or 0 when the divisor is out of range
  function automatic int exp_div(input logic [23:0] f);
    int d;
    d = f[15:0];
    if (f[16] || f[17]) return (d >= 272) ? (f[16] ? 2 * d : d) : 0;
    return (d >= 4 && d <= 4095) ? d : 0;
  endfunction : exp_div

  initial begin
    logic [31:0] d, w;
    logic [1:0]  r;
    logic [23:0] f;
    logic        b;
    logic        x;
    logic [23:0] frames[6];
    logic [23:0] doFrames[9];
    int          i, e, n;
    d = $urandom(32'hA61C0F53);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    axi_rd(4'h8, d, r);
    check32(d, 32'h0000_0004);
    check32({23'h0, portOe, ioOe, bandPortOe, serialOutOe}, 32'h0);
    $display("test reset done");
    for (i = 0; i < 2; i++) begin
      w = i ? ($urandom & 32'h1FF) : 32'h1FF;
      axi_wr(4'h0, w, r);
      check32({30'h0, r}, 32'h0);
      axi_rd(4'h0, d, r);
      check32(d, w);
      check32({25'h0, portOe, ioOe}, {25'h0, w[4:0], w[6:5] & w[8:7]});
    end
    axi_wr(4'h4, 32'h1, r);
    check32({30'h0, r}, 32'h2);
    axi_rd(4'hC, d, r);
    check32({r, d[29:0]}, 32'h8000_0000);
    axi_wr(4'h0, 32'h0, r);
    $display("test registers done");
    frames = '{24'h010110, 24'h020110, 24'h000004, 24'($urandom_range(60, 5)),
               24'h000003, 24'h01010F};
    for (i = 0; i < 6; i++) begin
      f = frames[i];
      curBand = f[16];
      CTRL.send(f, 24);
      axi_rd(4'h8, d, r);
      check32(d, {11'h0, f[20:0]});
      check32({31'h0, bandPortOe}, {31'h0, f[16]});
      e = exp_div(f);
      marks.delete();
      n = 0;
      while (marks.size() < 3 && n < (e ? 30000 : 3000)) begin
        @(posedge clk);
        n++;
      end
      check32(marks.size() >= 3 ? marks[2] - marks[1] : marks.size(), e);
      axi_rd(4'h4, d, r);
      check32({31'h0, d[4]}, {31'h0, e == 0});
    end
    CTRL.send(24'h0, 23);
    axi_rd(4'h8, d, r);
    check32(d, {11'h0, f[20:0]});
    $display("test divider done");
    // Every content code: band, both io pins, bad divisor, divided level, released
    doFrames = '{24'h150004, 24'h140004, 24'h080004, 24'h080004, 24'h000004,
                 24'h0C0004, 24'h110004, 24'h100004, 24'h040003};
    for (i = 0; i < 9; i++) begin
      f = doFrames[i];
      ioIn <= (i == 3) ? 2'h1 : (i == 5) ? 2'h2 : 2'h0;
      CTRL.send(f, 24);
      CTRL.fetch(b);
      case (f[20:18])
        3'h1:    x = pulseCnt[0];
        3'h2:    x = ioIn[0];
        3'h3:    x = ioIn[1];
        3'h4:    x = (exp_div(f) == 0);
        3'h5:    x = f[16];
        default: x = 1'b1;
      endcase
      check32({31'h0, b}, {31'h0, x});
    end
    $display("test data out done");
    report_and_stop();
  end
endmodule : pll_divider_input_select_bench
